// ### hw/gdsm_pkg.sv
// package: states, command codes and timing for the gauge state machine
package gdsm_pkg;
	typedef enum logic [3:0] {
		GDSM_INIT,
		GDSM_SELF_CHECK,
		GDSM_IDLE,
		GDSM_SELF_CHECK_FAILED,
		GDSM_EXECUTING,
		GDSM_ABORT,
		GDSM_UNRECOVERABLE
	} gdsm_state_t;

	localparam logic [7:0] CMD_INACTIVE      = 8'h00;
	localparam logic [7:0] CMD_RESET         = 8'h01;
	localparam logic [7:0] CMD_ABORT         = 8'h02;
	localparam logic [7:0] CMD_RECOVER       = 8'h03;
	localparam logic [7:0] CMD_EXECUTE       = 8'h04;
	localparam logic [7:0] CMD_STOP          = 8'h05;
	localparam logic [7:0] CMD_DIAGNOSTIC    = 8'h06;
	localparam logic [7:0] CMD_FACTORY_RESET = 8'h80;
	localparam logic [7:0] CMD_VENDOR_RESET  = 8'h81;

	localparam int CLOCK_MHZ            = 125;
	// quarter hour in seconds
	localparam int QUARTER_HOUR_S       = 900;
	localparam longint QUARTER_HOUR_CYC =
		longint'(QUARTER_HOUR_S) * 64'hF4240 * longint'(CLOCK_MHZ);
	localparam int RUNTIME_W            = 32;
	localparam int PRESCALE_W           = 40;
	localparam int DETAIL_W             = 8;
endpackage

// ### hw/gdsm_runtime.sv
// quarter-hour powered-on time counter
`timescale 1ns/1ps
module gdsm_runtime
	import gdsm_pkg::*;
#(
	parameter longint TICK_CYCLES = gdsm_pkg::QUARTER_HOUR_CYC
)
(
	// clock and reset
	input  wire logic                             clock,
	input  wire logic                             rst,
	// counter value
	output logic [gdsm_pkg::RUNTIME_W-1:0]        quarter_hour_runtime
);
	logic [PRESCALE_W-1:0] prescale;
	logic [PRESCALE_W-1:0] next_prescale;
	logic [RUNTIME_W-1:0]  next_runtime;
	logic                  tick;

	always_comb
	begin
		tick          = (prescale == PRESCALE_W'(TICK_CYCLES - 1));
		next_prescale = tick ? '0 : prescale + PRESCALE_W'(1);
		next_runtime  = tick ? quarter_hour_runtime + RUNTIME_W'(1)
			: quarter_hour_runtime;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			prescale             <= '0;
			quarter_hour_runtime <= '0;
		end
		else
		begin
			prescale             <= next_prescale;
			quarter_hour_runtime <= next_runtime;
		end
	end

	// R04: quarter hour step
	runtime_step_a: assert property (@(posedge clock) disable iff (rst) // R04
		tick |=> quarter_hour_runtime == $past(quarter_hour_runtime) + 1)
		else $error("runtime did not step");
	runtime_hold_a: assert property (@(posedge clock) disable iff (rst)
		!tick |=> $stable(quarter_hour_runtime)) // R04
		else $error("runtime changed off tick");
endmodule

// ### hw/gdsm_command.sv
// command code decoder: classifies a state command byte
`timescale 1ns/1ps
module gdsm_command
	import gdsm_pkg::*;
(
	// command in
	input  wire logic [7:0] cmd_code,
	// decoded
	output logic            is_reset,
	output logic            is_factory,
	output logic            is_abort,
	output logic            is_recover,
	output logic            is_execute,
	output logic            is_stop,
	output logic            is_diag
);
	// R21: inactive and reserved codes decode to nothing
	always_comb
	begin
		is_reset   = (cmd_code == CMD_RESET) || (cmd_code == CMD_VENDOR_RESET);
		is_factory = (cmd_code == CMD_FACTORY_RESET);
		is_abort   = (cmd_code == CMD_ABORT);
		is_recover = (cmd_code == CMD_RECOVER);
		is_execute = (cmd_code == CMD_EXECUTE);
		is_stop    = (cmd_code == CMD_STOP);
		is_diag    = (cmd_code == CMD_DIAGNOSTIC);
	end
endmodule

// ### hw/gdsm_top.sv
// device block state machine of a bus-attached vacuum gauge
// Summary of operation
// R01: start runs init, self-check, then idle/failed
// R02: cyclic exchange start enters executing
// R03: acyclic master must send start command
// R04: runtime counter steps each quarter hour
// R05: acyclic access allowed once blocks initialised
// R06: halted set: no measuring function
// R07: self-check runs with blocks initialised
// R08: idle means ready for cyclic transfer
// R09: self-check failure latches exception detail
// R10: executing measures and exchanges cyclic data
// R11: abort stops function, auto-recovers when clear
// R12: unrecoverable fault: no exit, result bad
// R13: codes not allowed in state are rejected
// R14: codes 1 and 129 reinitialise device
// R15: code 128 reinitialises and restores factory
// R16: code 2 enters abort
// R17: code 3 returns abort to idle
// R18: code 4 enters executing
// R19: code 5 enters idle
// R20: code 6 reruns self-check
// R21: code 0 and reserved codes ignored
`timescale 1ns/1ps
module gdsm_top
	import gdsm_pkg::*;
#(
	parameter longint TICK_CYCLES = gdsm_pkg::QUARTER_HOUR_CYC
)
(
	// clock and reset
	input  wire logic                           clock,
	input  wire logic                           rst,
	// board init and self-check results
	input  wire logic                           init_done,
	input  wire logic                           self_check_done,
	input  wire logic                           self_check_error,
	input  wire logic [gdsm_pkg::DETAIL_W-1:0]  self_check_detail,
	// fault sources
	input  wire logic                           abort_cause,
	input  wire logic                           fatal_fault,
	// link from the bus master
	input  wire logic                           cyclic_start,
	input  wire logic                           cmd_valid,
	input  wire logic [7:0]                     cmd_code,
	// command answer
	output logic                                cmd_accept,
	output logic                                cmd_reject,
	// state and activity
	output gdsm_pkg::gdsm_state_t               device_state,
	output logic                                acyclic_ready,
	output logic                                measure_enable,
	output logic                                cyclic_active,
	output logic                                result_bad,
	output logic                                self_check_run,
	output logic                                init_request,
	output logic                                factory_restore,
	output logic [gdsm_pkg::DETAIL_W-1:0]       exception_detail,
	output logic [gdsm_pkg::RUNTIME_W-1:0]      quarter_hour_runtime
);
	gdsm_state_t state;
	gdsm_state_t next_state;
	logic [DETAIL_W-1:0] next_detail;
	logic next_accept;
	logic next_reject;
	logic next_init_req;
	logic next_factory;
	logic is_reset;
	logic is_factory;
	logic is_abort;
	logic is_recover;
	logic is_execute;
	logic is_stop;
	logic is_diag;
	logic known;
	logic allowed;

	gdsm_command u_cmd (
		.cmd_code   (cmd_code),
		.is_reset   (is_reset),
		.is_factory (is_factory),
		.is_abort   (is_abort),
		.is_recover (is_recover),
		.is_execute (is_execute),
		.is_stop    (is_stop),
		.is_diag    (is_diag)
	);

	// R04: powered-on time
	gdsm_runtime #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_runtime (
		.clock                (clock),
		.rst                  (rst),
		.quarter_hour_runtime (quarter_hour_runtime)
	);

	always_comb
	begin
		known = is_reset | is_factory | is_abort | is_recover | is_execute
			| is_stop | is_diag;
		allowed = 1'b0;
		// R13: state-dependent permission
		unique case (state)
			GDSM_INIT,
			GDSM_UNRECOVERABLE:     allowed = 1'b0;
			GDSM_SELF_CHECK:        allowed = is_reset | is_factory | is_abort;
			GDSM_IDLE:              allowed = is_reset | is_factory | is_abort
				| is_execute | is_stop | is_diag;
			GDSM_SELF_CHECK_FAILED: allowed = is_reset | is_factory | is_diag;
			GDSM_EXECUTING:         allowed = is_reset | is_factory | is_abort
				| is_stop | is_diag | is_execute;
			GDSM_ABORT:             allowed = is_reset | is_factory | is_abort
				| is_recover | is_diag;
		endcase
	end

	always_comb
	begin
		next_state    = state;
		next_detail   = exception_detail;
		next_accept   = 1'b0;
		next_reject   = 1'b0;
		next_init_req = 1'b0;
		next_factory  = 1'b0;
		// R12: unrecoverable fault has no exit
		if (fatal_fault || state == GDSM_UNRECOVERABLE)
		begin
			next_state  = GDSM_UNRECOVERABLE;
			next_reject = cmd_valid && known;
		end
		else if (cmd_valid && known && allowed)
		begin
			next_accept = 1'b1;
			// R14: reinitialise bus side and base device
			if (is_reset)
			begin
				next_state    = GDSM_INIT;
				next_init_req = 1'b1;
			end
			// R15: reinitialise with factory settings
			else if (is_factory)
			begin
				next_state    = GDSM_INIT;
				next_init_req = 1'b1;
				next_factory  = 1'b1;
			end
			// R16: abort
			else if (is_abort)
				next_state = GDSM_ABORT;
			// R17: recover to idle
			else if (is_recover)
				next_state = GDSM_IDLE;
			// R18: execute
			else if (is_execute)
				next_state = GDSM_EXECUTING;
			// R19: stop to idle
			else if (is_stop)
				next_state = GDSM_IDLE;
			// R20: rerun self-check
			else
				next_state = GDSM_SELF_CHECK;
		end
		else
		begin
			// R13: refuse disallowed code
			next_reject = cmd_valid && known;
			unique case (state)
				// R01: init then self-check
				GDSM_INIT:
					if (init_done)
						next_state = GDSM_SELF_CHECK;
				GDSM_SELF_CHECK:
					if (self_check_done)
					begin
						// R09: latch exception detail
						if (self_check_error)
						begin
							next_state  = GDSM_SELF_CHECK_FAILED;
							next_detail = self_check_detail;
						end
						else
							next_state = GDSM_IDLE;
					end
				// R02: cyclic exchange starts execution
				GDSM_IDLE:
					if (cyclic_start)
						next_state = GDSM_EXECUTING;
				// R11: auto-return when cause clears
				GDSM_ABORT:
					if (!abort_cause)
						next_state = GDSM_IDLE;
				GDSM_SELF_CHECK_FAILED,
				GDSM_EXECUTING,
				GDSM_UNRECOVERABLE: next_state = state;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state            <= GDSM_INIT;
			exception_detail <= '0;
			cmd_accept       <= 1'b0;
			cmd_reject       <= 1'b0;
			init_request     <= 1'b0;
			factory_restore  <= 1'b0;
			device_state     <= GDSM_INIT;
			acyclic_ready    <= 1'b0;
			measure_enable   <= 1'b0;
			cyclic_active    <= 1'b0;
			result_bad       <= 1'b0;
			self_check_run   <= 1'b0;
		end
		else
		begin
			state            <= next_state;
			exception_detail <= next_detail;
			cmd_accept       <= next_accept;
			cmd_reject       <= next_reject;
			init_request     <= next_init_req;
			factory_restore  <= next_factory;
			device_state     <= next_state;
			// R05: acyclic access after init
			acyclic_ready    <= next_state != GDSM_INIT;
			// R06: measuring only when executing
			// R10: executing measures and exchanges cyclic data
			measure_enable   <= next_state == GDSM_EXECUTING;
			// R08: idle ready, cyclic active only executing
			cyclic_active    <= next_state == GDSM_EXECUTING;
			// R12: result bad in fault
			result_bad       <= next_state == GDSM_UNRECOVERABLE;
			// R07: self-check indicator
			self_check_run   <= next_state == GDSM_SELF_CHECK;
		end
	end

	sequence idle_s;
		state == GDSM_IDLE;
	endsequence
	sequence cyclic_s;
		cyclic_start && !cmd_valid && !fatal_fault;
	endsequence

	cyclic_exec_a: assert property (@(posedge clock) disable iff (rst) // R02
		idle_s and cyclic_s |=> device_state == GDSM_EXECUTING)
		else $error("cyclic start did not execute");
	init_check_a: assert property (@(posedge clock) disable iff (rst) // R01
		state == GDSM_INIT && init_done && !cmd_valid && !fatal_fault
		|=> state == GDSM_SELF_CHECK)
		else $error("init did not go to self-check");
	fail_detail_a: assert property (@(posedge clock) disable iff (rst) // R09
		state == GDSM_SELF_CHECK && self_check_done && self_check_error
		&& !cmd_valid && !fatal_fault
		|=> state == GDSM_SELF_CHECK_FAILED
		&& exception_detail == $past(self_check_detail))
		else $error("failure detail not latched");
	measure_exec_a: assert property (@(posedge clock) disable iff (rst) // R10
		measure_enable == (device_state == GDSM_EXECUTING)
		&& cyclic_active == measure_enable)
		else $error("measuring outside executing");
	fault_stuck_a: assert property (@(posedge clock) disable iff (rst) // R12
		state == GDSM_UNRECOVERABLE |=> state == GDSM_UNRECOVERABLE
		&& result_bad)
		else $error("left unrecoverable fault");
	abort_auto_a: assert property (@(posedge clock) disable iff (rst) // R11
		state == GDSM_ABORT && !abort_cause && !cmd_valid && !fatal_fault
		|=> state == GDSM_IDLE)
		else $error("abort did not recover");
	reject_cmd_a: assert property (@(posedge clock) disable iff (rst) // R13
		cmd_valid && known && !allowed |=> cmd_reject && !cmd_accept)
		else $error("disallowed code not rejected");
	// refused code leaves a state with no own exit untouched
	reject_hold_a: assert property (@(posedge clock) disable iff (rst) // R13
		cmd_valid && known && !allowed && !fatal_fault
		&& (state == GDSM_EXECUTING || state == GDSM_SELF_CHECK_FAILED)
		|=> $stable(state) && !init_request)
		else $error("refused code changed state");
	abort_cmd_a: assert property (@(posedge clock) disable iff (rst) // R16
		cmd_valid && is_abort && allowed && !fatal_fault
		|=> state == GDSM_ABORT && cmd_accept)
		else $error("abort command failed");
	reset_cmd_a: assert property (@(posedge clock) disable iff (rst) // R14
		cmd_valid && is_reset && allowed && !fatal_fault
		|=> state == GDSM_INIT && init_request && !factory_restore)
		else $error("reset command failed");
	factory_cmd_a: assert property (@(posedge clock) disable iff (rst) // R15
		cmd_valid && is_factory && allowed && !fatal_fault
		|=> init_request && factory_restore)
		else $error("factory reset failed");
	ignore_cmd_a: assert property (@(posedge clock) disable iff (rst) // R21
		cmd_valid && !known |=> !cmd_accept && !cmd_reject)
		else $error("ignored code answered");
	recover_cmd_a: assert property (@(posedge clock) disable iff (rst) // R17
		cmd_valid && is_recover && allowed && !fatal_fault
		|=> state == GDSM_IDLE && cmd_accept)
		else $error("recover command failed");
	execute_cmd_a: assert property (@(posedge clock) disable iff (rst) // R18
		cmd_valid && is_execute && allowed && !fatal_fault
		|=> device_state == GDSM_EXECUTING && measure_enable)
		else $error("execute command failed");
	stop_cmd_a: assert property (@(posedge clock) disable iff (rst) // R19
		cmd_valid && is_stop && allowed && !fatal_fault
		|=> state == GDSM_IDLE && !cyclic_active)
		else $error("stop command failed");
	diag_cmd_a: assert property (@(posedge clock) disable iff (rst) // R20
		cmd_valid && is_diag && allowed && !fatal_fault
		|=> state == GDSM_SELF_CHECK && self_check_run)
		else $error("diagnostic command failed");
endmodule

// ### verification/gdsm_master_model.sv
// bus master model: state command writes and cyclic start
`timescale 1ns/1ps
module gdsm_master_model
	import gdsm_pkg::*;
(
	// clock
	input  wire logic       clock,
	// command answer
	input  wire logic       cmd_accept,
	input  wire logic       cmd_reject,
	// to device
	output logic            cyclic_start,
	output logic            cmd_valid,
	output logic [7:0]      cmd_code
);
	initial
	begin
		cyclic_start = 1'b0;
		cmd_valid = 1'b0;
		cmd_code = 8'hFF;
	end
	task automatic send(input logic [7:0] code, output logic acc,
		output logic rej);
		@(negedge clock);
		cmd_valid = 1'b1;
		cmd_code = code;
		@(negedge clock);
		cmd_valid = 1'b0;
		// released line shows inverse, not the stale code
		cmd_code = ~code;
		acc = cmd_accept;
		rej = cmd_reject;
	endtask
	task automatic start_cyclic();
		@(negedge clock);
		cyclic_start = 1'b1;
		@(negedge clock);
		cyclic_start = 1'b0;
	endtask
endmodule

// ### verification/testbench.sv
// self-checking bench for the gauge device state machine
`timescale 1ns/1ps
module testbench;
	import gdsm_pkg::*;
	localparam longint TICKS = 10;
	logic        clock, rst, init_done, self_check_done, self_check_error;
	logic [7:0]  self_check_detail, cmd_code, exception_detail;
	logic        abort_cause, fatal_fault, cyclic_start, cmd_valid;
	logic        cmd_accept, cmd_reject, acyclic_ready, measure_enable;
	logic        cyclic_active, result_bad, self_check_run;
	logic        init_request, factory_restore, acc, rej;
	logic [31:0] quarter_hour_runtime, v;
	gdsm_state_t device_state;
	int          bad_count = 0;
	int          comparisons = 0;
	int          cycles = 0;

	gdsm_top #(.TICK_CYCLES(TICKS)) uut (.clock(clock), .rst(rst),
		.init_done(init_done), .self_check_done(self_check_done),
		.self_check_error(self_check_error),
		.self_check_detail(self_check_detail), .abort_cause(abort_cause),
		.fatal_fault(fatal_fault), .cyclic_start(cyclic_start),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_accept(cmd_accept), .cmd_reject(cmd_reject),
		.device_state(device_state), .acyclic_ready(acyclic_ready),
		.measure_enable(measure_enable), .cyclic_active(cyclic_active),
		.result_bad(result_bad), .self_check_run(self_check_run),
		.init_request(init_request), .factory_restore(factory_restore),
		.exception_detail(exception_detail),
		.quarter_hour_runtime(quarter_hour_runtime));
	gdsm_master_model master (.clock(clock), .cmd_accept(cmd_accept),
		.cmd_reject(cmd_reject), .cyclic_start(cyclic_start),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code));

	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic complete_run();
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			bad_count++;
			complete_run();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] c, input logic a, input logic r,
		input gdsm_state_t s);
		master.send(c, acc, rej);
		chk({acc, rej}, {a, r});
		chk(device_state, s);
	endtask
	task automatic wait_state(input gdsm_state_t s);
		int n;
		n = 0;
		while (device_state !== s && n < 20)
		begin
			@(negedge clock);
			n++;
		end
		chk(device_state, s);
	endtask
	task automatic boot(input logic err, input logic [7:0] det);
		@(negedge clock);
		init_done = 1'b1;
		self_check_done = 1'b1;
		self_check_error = err;
		self_check_detail = det;
		wait_state(err ? GDSM_SELF_CHECK_FAILED : GDSM_IDLE);
		init_done = 1'b0;
		self_check_done = 1'b0;
		self_check_error = 1'b0;
	endtask

	task automatic t_start();
		boot(1'b0, 8'h00);
		chk(acyclic_ready, 1'b1);
		chk(measure_enable, 1'b0);
		chk(cyclic_active, 1'b0);
		repeat (3) @(negedge clock);
		chk(device_state, GDSM_IDLE);
		master.start_cyclic();
		chk(device_state, GDSM_EXECUTING);
		chk({measure_enable, cyclic_active}, 2'h3);
		$display("test start done");
	endtask
	task automatic t_cmds();
		abort_cause = 1'b1;
		cmd(8'h03, 1'b0, 1'b1, GDSM_EXECUTING);
		cmd(8'h00, 1'b0, 1'b0, GDSM_EXECUTING);
		cmd(8'hC8, 1'b0, 1'b0, GDSM_EXECUTING);
		cmd(8'h7F, 1'b0, 1'b0, GDSM_EXECUTING);
		cmd(8'h02, 1'b1, 1'b0, GDSM_ABORT);
		chk({measure_enable, cyclic_active}, 2'h0);
		cmd(8'h05, 1'b0, 1'b1, GDSM_ABORT);
		cmd(8'h03, 1'b1, 1'b0, GDSM_IDLE);
		abort_cause = 1'b0;
		cmd(8'h04, 1'b1, 1'b0, GDSM_EXECUTING);
		cmd(8'h05, 1'b1, 1'b0, GDSM_IDLE);
		cmd(8'h06, 1'b1, 1'b0, GDSM_SELF_CHECK);
		chk({self_check_run, measure_enable}, 2'h2);
		boot(1'b0, 8'h00);
		$display("test commands done");
	endtask
	task automatic t_auto_recover();
		abort_cause = 1'b1;
		cmd(8'h02, 1'b1, 1'b0, GDSM_ABORT);
		repeat (3) @(negedge clock);
		chk(device_state, GDSM_ABORT);
		abort_cause = 1'b0;
		wait_state(GDSM_IDLE);
		$display("test auto recover done");
	endtask
	task automatic t_resets();
		logic [7:0] codes [3] = '{8'h01, 8'h81, 8'h80};
		foreach (codes[i])
		begin
			cmd(codes[i], 1'b1, 1'b0, GDSM_INIT);
			chk(init_request, 1'b1);
			chk(factory_restore, codes[i] == 8'h80);
			boot(1'b0, 8'h00);
		end
		$display("test resets done");
	endtask
	task automatic t_fail();
		cmd(8'h06, 1'b1, 1'b0, GDSM_SELF_CHECK);
		boot(1'b1, 8'hA5);
		chk(exception_detail, 8'hA5);
		cmd(8'h04, 1'b0, 1'b1, GDSM_SELF_CHECK_FAILED);
		cmd(8'h06, 1'b1, 1'b0, GDSM_SELF_CHECK);
		boot(1'b0, 8'h00);
		$display("test self check fail done");
	endtask
	task automatic t_runtime();
		@(negedge clock);
		v = quarter_hour_runtime;
		repeat (TICKS) @(negedge clock);
		chk(quarter_hour_runtime, v + 32'h1);
		$display("test runtime done");
	endtask
	task automatic t_fatal();
		@(negedge clock);
		fatal_fault = 1'b1;
		@(negedge clock);
		fatal_fault = 1'b0;
		chk(device_state, GDSM_UNRECOVERABLE);
		chk({result_bad, cyclic_active}, 2'h2);
		repeat (3) @(negedge clock);
		cmd(8'h01, 1'b0, 1'b1, GDSM_UNRECOVERABLE);
		$display("test fatal done");
	endtask
	task automatic t_rst();
		@(negedge clock);
		rst = 1'b1;
		repeat (2) @(negedge clock);
		rst = 1'b0;
		chk(device_state, GDSM_INIT);
		chk({cmd_accept, cmd_reject, acyclic_ready, measure_enable,
			cyclic_active, result_bad, self_check_run, init_request,
			factory_restore}, 32'h0);
		chk(quarter_hour_runtime, 32'h0);
		boot(1'b0, 8'h00);
		$display("test mid-run reset done");
	endtask

	initial
	begin
		rst = 1'b1;
		init_done = 1'b0;
		self_check_done = 1'b0;
		self_check_error = 1'b0;
		self_check_detail = 8'h00;
		abort_cause = 1'b0;
		fatal_fault = 1'b0;
		repeat (12) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		chk(device_state, GDSM_INIT);
		t_start();
		t_cmds();
		t_auto_recover();
		t_runtime();
		t_resets();
		t_fail();
		t_fatal();
		t_rst();
		complete_run();
	end
endmodule
